/* flr_regs.sv */
// Fault log and ADC result register bank
`timescale 1ns/1ps
module flr_regs
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire flr_pkg::flr_bus_s bus_i,
    output logic [7:0]            rdata_o,
    output logic                  rvalid_o,
    input  wire flr_pkg::flr_adc_s adc_i,
    input  wire logic             fet_cmd_on_i,
    input  wire logic             insert_detect_i,
    input  wire logic             output_feedback_pin_i,
    input  wire logic             overcurrent_event_i,
    input  wire logic             cool_down_i,
    input  wire logic             low_supply_comparator_input_i,
    input  wire logic             high_supply_comparator_input_i,
    input  wire logic [5:0]       alert_enable_i,
    output logic                  alert_o,
    output logic                  oc_status_o
);

    // ************************************************************
    // Event detection
    // ************************************************************
    logic       en_prev_q;
    logic       en_prev_d;
    logic       uv_prev_q;
    logic       uv_prev_d;
    logic       ov_prev_q;
    logic       ov_prev_d;
    logic       armed_q;
    logic       armed_d;
    logic [5:0] fault_q;
    logic [5:0] fault_d;
    logic [5:0] event_w;
    logic [7:0] sense_q;
    logic [7:0] outv_q;
    logic [7:0] aux_q;

    // Level conditions set their bit again on every cycle that they hold
    wire short_w = !fet_cmd_on_i && (sense_q > flr_pkg::FLR_SHORT_CODE);
    wire pbad_w  = !output_feedback_pin_i;
    wire oc_w    = overcurrent_event_i;

    // Edges are ignored until the first sample after reset sets the baseline,
    // otherwise the reset value of a previous-level flop would fake an edge
    wire enchg_w = armed_q && (insert_detect_i != en_prev_q);
    wire uv_w    = armed_q && uv_prev_q && !low_supply_comparator_input_i;
    wire ov_w    = armed_q && !ov_prev_q && high_supply_comparator_input_i;

    assign event_w[flr_pkg::FLR_BIT_SHORT] = short_w;
    assign event_w[flr_pkg::FLR_BIT_ENCHG] = enchg_w;
    assign event_w[flr_pkg::FLR_BIT_PBAD]  = pbad_w;
    assign event_w[flr_pkg::FLR_BIT_OC]    = oc_w;
    assign event_w[flr_pkg::FLR_BIT_UV]    = uv_w;
    assign event_w[flr_pkg::FLR_BIT_OV]    = ov_w;

    // ************************************************************
    // Previous pin levels
    // ************************************************************
    assign en_prev_d = insert_detect_i;
    assign uv_prev_d = low_supply_comparator_input_i;
    assign ov_prev_d = high_supply_comparator_input_i;
    assign armed_d   = 1'b1;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            en_prev_q <= 1'b0;
        end
        else
        begin
            en_prev_q <= en_prev_d;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            uv_prev_q <= 1'b0;
        end
        else
        begin
            uv_prev_q <= uv_prev_d;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ov_prev_q <= 1'b0;
        end
        else
        begin
            ov_prev_q <= ov_prev_d;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            armed_q <= 1'b0;
        end
        else
        begin
            armed_q <= armed_d;
        end
    end

    // ************************************************************
    // Register decode
    // ************************************************************
    wire wr_fault_w = bus_i.wr && (bus_i.addr == flr_pkg::FLR_OFF_FAULT);
    wire wr_sense_w = bus_i.wr && (bus_i.addr == flr_pkg::FLR_OFF_SENSE);
    wire wr_outv_w  = bus_i.wr && (bus_i.addr == flr_pkg::FLR_OFF_OUTV);
    wire wr_aux_w   = bus_i.wr && (bus_i.addr == flr_pkg::FLR_OFF_AUX);
    wire adc_s_w    = adc_i.valid && (adc_i.chan == flr_pkg::FLR_CH_SENSE);
    wire adc_o_w    = adc_i.valid && (adc_i.chan == flr_pkg::FLR_CH_OUTV);
    wire adc_a_w    = adc_i.valid && (adc_i.chan == flr_pkg::FLR_CH_AUX);

    // Host write keeps only bits written one; any event in the same cycle still sets
    wire [5:0] keep_w = wr_fault_w ? (bus_i.wdata[5:0] & flr_pkg::FLR_FAULT_MASK)
                                   : flr_pkg::FLR_FAULT_MASK;

    genvar gi;
    generate
        for (gi = 0; gi < flr_pkg::FLR_NUM_FLT; gi++)
        begin : g_flt
            assign fault_d[gi] = event_w[gi] | (fault_q[gi] & keep_w[gi]);
        end
    endgenerate

    // ************************************************************
    // Fault log
    // ************************************************************
    // A fault bit is only ever cleared by a host write or by reset; nothing here clears it alone
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            fault_q <= flr_pkg::FLR_FAULT_RST[5:0];
        end
        else
        begin
            fault_q <= fault_d;
        end
    end

    // ************************************************************
    // Measurement results
    // ************************************************************
    // Conversion result takes priority over a host write in the same cycle,
    // so a host write can never pin a stale value over a fresh conversion
    wire [7:0] sense_d = adc_s_w    ? adc_i.code  :
                         wr_sense_w ? bus_i.wdata : sense_q;
    wire [7:0] outv_d  = adc_o_w    ? adc_i.code  :
                         wr_outv_w  ? bus_i.wdata : outv_q;
    wire [7:0] aux_d   = adc_a_w    ? adc_i.code  :
                         wr_aux_w   ? bus_i.wdata : aux_q;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sense_q <= flr_pkg::FLR_RESULT_RST;
        end
        else
        begin
            sense_q <= sense_d;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            outv_q <= flr_pkg::FLR_RESULT_RST;
        end
        else
        begin
            outv_q <= outv_d;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            aux_q <= flr_pkg::FLR_RESULT_RST;
        end
        else
        begin
            aux_q <= aux_d;
        end
    end

    // ************************************************************
    // Read decode
    // ************************************************************
    // Unmapped offsets read zero and the reserved fault bits are tied low
    wire       hit_fault_w = (bus_i.addr == flr_pkg::FLR_OFF_FAULT);
    wire       hit_sense_w = (bus_i.addr == flr_pkg::FLR_OFF_SENSE);
    wire       hit_outv_w  = (bus_i.addr == flr_pkg::FLR_OFF_OUTV);
    wire       hit_aux_w   = (bus_i.addr == flr_pkg::FLR_OFF_AUX);
    wire [7:0] fault_rd_w  = {2'h0, fault_q};
    wire [7:0] rmux_w      = ({8{hit_fault_w}} & fault_rd_w)
                           | ({8{hit_sense_w}} & sense_q)
                           | ({8{hit_outv_w}}  & outv_q)
                           | ({8{hit_aux_w}}   & aux_q);

    // ************************************************************
    // Output flops
    // ************************************************************
    // Read data holds the last value read, so the host may take it late
    wire [7:0] rdata_d     = bus_i.rd ? rmux_w : rdata_o;
    wire       rvalid_d    = bus_i.rd;
    wire [5:0] alert_hit_w = fault_q & alert_enable_i;
    wire       alert_d     = |alert_hit_w;
    // Live status only; the latched overcurrent bit is kept apart in the log
    wire       oc_status_d = cool_down_i && overcurrent_event_i;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdata_o <= 8'h00;
        end
        else
        begin
            rdata_o <= rdata_d;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rvalid_o <= 1'b0;
        end
        else
        begin
            rvalid_o <= rvalid_d;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            alert_o <= 1'b0;
        end
        else
        begin
            alert_o <= alert_d;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            oc_status_o <= 1'b0;
        end
        else
        begin
            oc_status_o <= oc_status_d;
        end
    end

endmodule // flr_regs

/* flr_pkg.sv */
// Package of constants and types for the fault log and measurement registers
// Operation
// - Set short-transistor flag when sense reading exceeds 1 mV while transistor is off.
// - Set enable-change flag whenever the insertion-detect pin changes level.
// - Set power-bad flag while the output feedback pin is low.
// - Set overcurrent flag when an overcurrent fault event occurs.
// - Set undervoltage flag when the low-supply comparator input falls low.
// - Set overvoltage flag when the high-supply comparator input rises high.
// - Current-sense result is an 8-bit code at offset 04h, 151 uV steps.
// - Output voltage result is an 8-bit code at offset 05h, 60.5 mV steps.
// - Auxiliary input result is an 8-bit code at offset 06h, 4.82 mV steps.
// - Alert output only for logged faults whose enable bit is one; enables reset zero. Here enables come straight from alert_enable_i, with no register.
// - Live overcurrent status is reported only during the cool-down cycle.
package flr_pkg;

    localparam logic [7:0] FLR_OFF_FAULT  = 8'h03;
    localparam logic [7:0] FLR_OFF_SENSE  = 8'h04;
    localparam logic [7:0] FLR_OFF_OUTV   = 8'h05;
    localparam logic [7:0] FLR_OFF_AUX    = 8'h06;

    localparam int FLR_BIT_SHORT = 5;
    localparam int FLR_BIT_ENCHG = 4;
    localparam int FLR_BIT_PBAD  = 3;
    localparam int FLR_BIT_OC    = 2;
    localparam int FLR_BIT_UV    = 1;
    localparam int FLR_BIT_OV    = 0;
    localparam int FLR_NUM_FLT   = 6;

    localparam logic [5:0] FLR_FAULT_MASK  = 6'h3f;
    localparam logic [7:0] FLR_FAULT_RST   = 8'h00;
    localparam logic [7:0] FLR_RESULT_RST  = 8'h00;
    localparam logic [5:0] FLR_ALERT_RST   = 6'h00;

    // Sense code above which the transistor counts as shorted: 1 mV over 151 uV steps
    localparam int         FLR_SHORT_UV     = 1000;
    localparam int         FLR_SENSE_LSB_NV = 151000;
    localparam logic [7:0] FLR_SHORT_CODE   = 8'((FLR_SHORT_UV * 1000) / FLR_SENSE_LSB_NV);

    // ADC channel selector
    localparam logic [1:0] FLR_CH_SENSE = 2'h0;
    localparam logic [1:0] FLR_CH_OUTV  = 2'h1;
    localparam logic [1:0] FLR_CH_AUX   = 2'h2;

    typedef struct packed {
        logic       valid;
        logic [1:0] chan;
        logic [7:0] code;
    } flr_adc_s;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } flr_bus_s;

endpackage

/* flr_regs_monitor.sv */
// Port checker of the fault log and result register bank
`timescale 1ns/1ps
module flr_regs_monitor
(
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire flr_pkg::flr_bus_s bus_i,
    input wire logic [7:0]        rdata_o,
    input wire logic              rvalid_o,
    input wire flr_pkg::flr_adc_s adc_i,
    input wire logic              output_feedback_pin_i,
    input wire logic              overcurrent_event_i,
    input wire logic              cool_down_i,
    input wire logic              high_supply_comparator_input_i,
    input wire logic [5:0]        alert_enable_i,
    input wire logic              alert_o,
    input wire logic              oc_status_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ****
    // Assertions
    // ****
    wire rd_f = bus_i.rd && bus_i.addr == flr_pkg::FLR_OFF_FAULT;
    wire rd_s = bus_i.rd && bus_i.addr == flr_pkg::FLR_OFF_SENSE;
    oc_live_a: assert property (
        cool_down_i |=> oc_status_o == $past(overcurrent_event_i)) else $error("oc status wrong");
    oc_idle_a: assert property (!cool_down_i |=> !oc_status_o)
        else $error("oc status outside cool-down");
    alert_mask_a: assert property (alert_enable_i == 6'h00 |=> !alert_o)
        else $error("alert while masked");
    alert_set_a: assert property (
        overcurrent_event_i ##1 alert_enable_i[2] |=> alert_o) else $error("alert missing");
    pbad_log_a: assert property (!output_feedback_pin_i ##1 rd_f |=> rdata_o[3])
        else $error("power-bad bit not logged");
    ov_log_a: assert property (
        !high_supply_comparator_input_i ##1 high_supply_comparator_input_i ##1 rd_f
        |=> rdata_o[0]) else $error("overvoltage bit not logged");
    reserved_zero_a: assert property (
        rvalid_o && $past(bus_i.addr) == flr_pkg::FLR_OFF_FAULT |-> rdata_o[7:6] == 2'h0)
        else $error("reserved bits not zero");
    sense_result_a: assert property (
        adc_i.valid && adc_i.chan == flr_pkg::FLR_CH_SENSE ##1 !adc_i.valid ##1 rd_s
        |=> rdata_o == $past(adc_i.code, 3)) else $error("sense result wrong");
    cover property (rd_f ##1 rdata_o != 8'h00);
    cover property ($rose(alert_o));
    cover property ($rose(oc_status_o));
endmodule // flr_regs_monitor

/* flr_host.sv */
// Host model issuing register bus accesses
`timescale 1ns/1ps
module flr_host
(
    input  wire logic         clk_i,
    input  wire logic [7:0]   rdata_i,
    input  wire logic         rvalid_i,
    output flr_pkg::flr_bus_s bus_o
);
    initial bus_o = '{wr:1'b0, rd:1'b0, addr:8'h00, wdata:8'h00};
    // ****
    // One access; a released bus shows inverted values, never the last ones
    // ****
    task automatic access(input logic w, input logic [7:0] a, d, output logic [7:0] q);
        @(posedge clk_i);
        bus_o <= '{wr:w, rd:!w, addr:a, wdata:d};
        @(posedge clk_i);
        bus_o <= '{wr:1'b0, rd:1'b0, addr:~a, wdata:~d};
        @(posedge clk_i);
        q = rvalid_i ? rdata_i : 8'hxx;
    endtask
endmodule // flr_host

/* fault_log_and_adc_result_registers_tb.sv */
// Self-checking bench of the fault log and result register bank
`timescale 1ns/1ps
module fault_log_and_adc_result_registers_tb;
    typedef struct packed { logic [1:0] ch; logic [7:0] code; logic [7:0] off; } flr_row_s;
    localparam flr_row_s ROWS [4] = '{'{2'h1, 8'h5a, 8'h05}, '{2'h2, 8'ha5, 8'h06},
                                      '{2'h0, 8'hff, 8'h04}, '{2'h0, 8'h00, 8'h04}};
    logic clk_i = 1'b0, rst_i = 1'b1, fet_on = 1'b1, ins = 1'b0, fb = 1'b1, oc = 1'b0;
    logic cool = 1'b0, lo = 1'b1, hi = 1'b0, rvalid, alert, ocs;
    logic [5:0] en = 6'h00;
    logic [7:0] q, rdata;
    flr_pkg::flr_adc_s adc = '0;
    flr_pkg::flr_bus_s bus;
    int fail_count = 0, comparisons = 0;
    always #4 clk_i = ~clk_i;
    flr_host i_host (.clk_i, .rdata_i(rdata), .rvalid_i(rvalid), .bus_o(bus));
    flr_regs i_dut (.clk_i, .rst_i, .bus_i(bus), .rdata_o(rdata), .rvalid_o(rvalid), .adc_i(adc),
        .fet_cmd_on_i(fet_on), .insert_detect_i(ins), .output_feedback_pin_i(fb),
        .overcurrent_event_i(oc), .cool_down_i(cool), .low_supply_comparator_input_i(lo),
        .high_supply_comparator_input_i(hi), .alert_enable_i(en), .alert_o(alert),
        .oc_status_o(ocs));
    // ****
    // Tasks
    // ****
    task automatic check(input logic [7:0] seen, exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, exp);
        i_host.access(1'b0, a, 8'h00, q);
        check(q, exp);
    endtask
    task automatic wr(input logic [7:0] a, d);
        i_host.access(1'b1, a, d, q);
    endtask
    // Valid is dropped one edge before the read starts
    task automatic conv(input logic [1:0] c, input logic [7:0] k);
        @(posedge clk_i);
        adc <= '{valid:1'b1, chan:c, code:k};
        @(posedge clk_i);
        adc.valid <= 1'b0;
    endtask
    task automatic give_verdict;
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            conv(ROWS[i].ch, ROWS[i].code);
            rd(ROWS[i].off, ROWS[i].code);
        end
        rd(8'h07, 8'h00);
        // Sense code 6 sits just under the short threshold
        conv(flr_pkg::FLR_CH_SENSE, 8'h06);
        {fet_on, ins, oc, lo, en} <= {4'h6, 6'h04};
        @(posedge clk_i);
        {oc, lo, fb, hi} <= 4'h5;
        rd(flr_pkg::FLR_OFF_FAULT, 8'h1f);
        check({7'h00, alert}, 8'h01);
        {fb, en} <= {1'b1, 6'h00};
        wr(flr_pkg::FLR_OFF_FAULT, 8'hff);
        rd(flr_pkg::FLR_OFF_FAULT, 8'h1f);
        wr(flr_pkg::FLR_OFF_FAULT, 8'h00);
        rd(flr_pkg::FLR_OFF_FAULT, 8'h00);
        check({7'h00, alert}, 8'h00);
        conv(flr_pkg::FLR_CH_SENSE, 8'h07);
        rd(flr_pkg::FLR_OFF_FAULT, 8'h20);
        {cool, oc} <= 2'h3;
        repeat (2) @(posedge clk_i);
        check({7'h00, ocs}, 8'h01);
        cool <= 1'b0;
        repeat (2) @(posedge clk_i);
        check({7'h00, ocs}, 8'h00);
        // Overcurrent and short still present: a clear cannot outrun them
        wr(flr_pkg::FLR_OFF_FAULT, 8'h00);
        rd(flr_pkg::FLR_OFF_FAULT, 8'h24);
        {rst_i, oc} <= 2'h2;
        @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 3; a < 7; a++)
            rd(8'(a), 8'h00);
        give_verdict;
    end
    initial
    begin
        #20000;
        fail_count++;
        give_verdict;
    end
endmodule // fault_log_and_adc_result_registers_tb
bind flr_regs flr_regs_monitor i_mon (.clk_i, .rst_i, .bus_i, .rdata_o, .rvalid_o, .adc_i,
    .output_feedback_pin_i, .overcurrent_event_i, .cool_down_i,
    .high_supply_comparator_input_i, .alert_enable_i, .alert_o, .oc_status_o);
